// [hdl/apg_cfg.svh]
/*
  Constants for the axis pulse, gear, backlash and alarm block.
  Assumes inclusion by bare name from the design modules and the bench.
*/
`ifndef APG_CFG_SVH
`define APG_CFG_SVH
// ==========================================================
// Register word offsets (byte address = 4 * index)
`define APG_REG_BL_MODE    4'h0
`define APG_REG_ALM_POL    4'h1
`define APG_REG_ALM_MASK   4'h2
`define APG_REG_DIR_INV    4'h3
`define APG_REG_INT_STAT   4'h4
`define APG_REG_INT_MASK   4'h5
`define APG_REG_ALM_STAT   4'h6
`define APG_REG_BUSY       4'h7
`define APG_REG_GEAR_NUM   4'h8
`define APG_REG_GEAR_DEN   4'h9
`define APG_REG_BL_AMT     4'ha
`define APG_REG_BL_CFG     4'hb
// ==========================================================
// Field positions
`define APG_BL_WAIT_BIT    0
`define APG_BL_VEL_BIT     7
`define APG_SPINDLE_ALARM_MASK_BIT       2
`define APG_FEED_ALARM_MASK_BIT       5
// ==========================================================
// Reset values
`define APG_BL_MODE_RST    8'h00
`define APG_ALM_POL_RST    8'h00
`define APG_ALM_MASK_RST   8'h00
`define APG_DIR_INV_RST    8'h00
`define APG_GEAR_RST       16'h0001
`define APG_BL_AMT_RST     16'h0000
`define APG_BL_CFG_RST     8'h10
// ==========================================================
// Timing: fixed-frequency divisor scale and acceleration ramp
`define APG_BL_DIV_SCALE   8'h10
`define APG_BL_RAMP_START  12'h400
`endif

// [hdl/apg_pkg.sv]
/*
  Types shared by the axis block and its per-axis channel.
  Assumes apg_cfg.svh holds the numbers.
*/
package apg_pkg;
  // ==========================================================
  // Per-axis command pulse carrier
  typedef struct packed {
    logic step;
    logic dir_neg;
  } apg_pulse_s;
  // Backlash engine state
  typedef enum logic [1:0] {
    APG_IDLE,
    APG_BL_RUN
  } apg_state_e;
  typedef logic [15:0] apg_word_t;
endpackage

// [hdl/apg_axis.sv]
/*
  One axis channel: electronic gear, backlash insertion, direction invert.
  Assumes commands are one-cycle step pulses synchronous to i_sys_clk.
*/
`timescale 1ns/10ps
`include "apg_cfg.svh"
module apg_axis (
  input  wire logic                i_sys_clk,
  input  wire logic                i_nrst,
  input  wire logic                i_ce,
  input  wire apg_pkg::apg_pulse_s i_cmd,
  input  wire apg_pkg::apg_word_t  i_gear_num,
  input  wire apg_pkg::apg_word_t  i_gear_den,
  input  wire apg_pkg::apg_word_t  i_bl_amount,
  input  wire logic [7:0]          i_bl_cfg,
  input  wire logic                i_vel_method,
  input  wire logic                i_dir_inv,
  output apg_pkg::apg_pulse_s      o_out,
  output logic                     o_bl_busy,
  output logic                     o_bl_done
);
  // ==========================================================
  // Gear accumulator state
  logic [16:0]         acc;
  logic [15:0]         pend;
  logic                last_dir;
  logic                dir_known;
  apg_pkg::apg_state_e state;
  logic [15:0]         bl_left;
  logic [11:0]         bl_div;
  logic [11:0]         bl_cnt;
  logic [11:0]         base_div;
  logic                rev;
  logic [16:0]         gear_sum;
  logic                gear_carry;
  logic                drain;
  logic                bl_fire;
  assign base_div = {i_bl_cfg, 4'h0} | 12'h001;
  assign rev      = i_cmd.step && dir_known && (i_cmd.dir_neg != last_dir);
  // Carry out of the gear accumulator gives one scaled step
  assign gear_sum   = acc + (i_cmd.step ? {1'b0, i_gear_num} : 17'h00000);
  assign gear_carry = (gear_sum >= {1'b0, i_gear_den}) && (i_gear_den != 16'h0000);
  // A low cycle after each output step, so the drive sees separate pulses
  assign drain      = (pend != 16'h0000) && (state == apg_pkg::APG_IDLE) && !o_out.step;
  assign bl_fire    = (state == apg_pkg::APG_BL_RUN) && (bl_cnt + 12'h001 >= bl_div)
                      && !o_out.step;

  // gear scaling: num/den pulses per command pulse
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      acc  <= 17'h00000;
      pend <= 16'h0000;
    end else if (i_ce) begin
      if (gear_carry) begin
        acc <= gear_sum - {1'b0, i_gear_den};
      end else begin
        acc <= gear_sum;
      end
      // Pending scaled steps; drained one at a time when not compensating
      if (gear_carry && !drain) begin
        pend <= pend + 16'h0001;
      end else if (!gear_carry && drain) begin
        pend <= pend - 16'h0001;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      last_dir  <= 1'b0;
      dir_known <= 1'b0;
    end else if (i_ce && i_cmd.step) begin
      last_dir  <= i_cmd.dir_neg;
      dir_known <= 1'b1;
    end
  end

  // backlash engine, fixed or ramped rate
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state   <= apg_pkg::APG_IDLE;
      bl_left <= 16'h0000;
      bl_div  <= 12'h000;
      bl_cnt  <= 12'h000;
    end else if (i_ce) begin
      case (state)
        apg_pkg::APG_IDLE: begin
          if (rev && i_bl_amount != 16'h0000) begin
            state   <= apg_pkg::APG_BL_RUN;
            bl_left <= i_bl_amount;
            bl_div  <= i_vel_method ? `APG_BL_RAMP_START : base_div;
            bl_cnt  <= 12'h000;
          end
        end
        apg_pkg::APG_BL_RUN: begin
          if (bl_fire) begin
            bl_cnt  <= 12'h000;
            bl_left <= bl_left - 16'h0001;
            // Ramp: halve period toward base while far, lengthen near end
            if (i_vel_method) begin
              if (bl_left > 16'h0008 && (bl_div >> 1) >= base_div) begin
                bl_div <= bl_div >> 1;
              end else if (bl_left <= 16'h0008 && bl_div < `APG_BL_RAMP_START) begin
                bl_div <= bl_div << 1;
              end
            end
            if (bl_left == 16'h0001) begin
              state <= apg_pkg::APG_IDLE;
            end
          end else begin
            bl_cnt <= bl_cnt + 12'h001;
          end
        end
        default: state <= apg_pkg::APG_IDLE;
      endcase
    end
  end

  // output direction inversion; backlash takes new dir
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_out     <= '0;
      o_bl_done <= 1'b0;
    end else if (i_ce) begin
      o_bl_done   <= bl_fire && (bl_left == 16'h0001);
      o_out.dir_neg <= last_dir ^ i_dir_inv;
      if (state == apg_pkg::APG_BL_RUN) begin
        o_out.step <= bl_fire;
      end else begin
        o_out.step <= drain;
      end
    end
  end
  assign o_bl_busy = (state != apg_pkg::APG_IDLE);
endmodule

// [hdl/apg_top.sv]
/*
  Five-axis position pulse output with electronic gear, backlash
  compensation, direction inversion and drive alarm supervision,
  reached over an Avalon-MM slave with waitrequest.
  Assumes all inputs synchronous to i_sys_clk (20 MHz) and one reset.
*/
`timescale 1ns/10ps
`include "apg_cfg.svh"
module apg_top (
  input  wire logic                i_sys_clk,
  input  wire logic                i_nrst,
  input  wire logic                i_ce,
  // Avalon-MM slave
  input  wire logic [5:0]          i_avs_address,
  input  wire logic                i_avs_read,
  input  wire logic                i_avs_write,
  input  wire logic [31:0]         i_avs_writedata,
  input  wire logic [3:0]          i_avs_byteenable,
  output logic [31:0]              o_avs_readdata,
  output logic                     o_avs_waitrequest,
  // Motion command and drive side
  input  wire apg_pkg::apg_pulse_s i_cmd [5],
  output apg_pkg::apg_pulse_s      o_drv [5],
  input  wire logic [4:0]          i_axis_alarm,
  input  wire logic                i_spindle_alarm,
  input  wire logic                i_alarm_reset,
  output logic                     o_block_hold,
  output logic [5:0]               o_drive_alarm,
  output logic                     o_irq
);
  // ==========================================================
  // Registers
  logic [7:0]         backlash_mode_settings;
  logic [7:0]         drive_alarm_polarity;
  logic [7:0]         drive_alarm_masks;
  logic [7:0]         dir_invert;
  logic [7:0]         int_status;
  logic [7:0]         int_mask;
  apg_pkg::apg_word_t gear_num [5];
  apg_pkg::apg_word_t gear_den [5];
  apg_pkg::apg_word_t bl_amount [5];
  logic [7:0]         bl_cfg [5];
  logic [4:0]         bl_busy;
  logic [4:0]         bl_done;
  logic [5:0]         raw_alarm;
  logic               ack;
  logic [3:0]         idx;
  logic [2:0]         axis_sel;
  logic               wr;
  logic               rd;
  logic [7:0]         int_ev;

  // Register index decode, used for reads and writes
  // Words 0xc..0xf are the fifth axis bank, in the order of words 0x8..0xb
  function automatic logic [3:0] reg_index(input logic [5:0] a);
    reg_index = (a[5:4] == 2'h3) ? {2'h2, a[3:2]} : a[5:2];
  endfunction
  function automatic logic [2:0] axis_index(input logic [5:0] a);
    axis_index = (a[5:4] == 2'h3) ? 3'h4 : {1'b0, a[1:0]};
  endfunction

  assign idx      = reg_index(i_avs_address);
  assign axis_sel = axis_index(i_avs_address);
  assign wr       = i_avs_write && ack;
  assign rd       = i_avs_read && ack;
  // One wait cycle per access; answer on second edge
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack;

  // ==========================================================
  // Bus handshake
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ack <= 1'b0;
    end else if (i_ce) begin
      ack <= (i_avs_read || i_avs_write) && !ack;
    end
  end

  // ==========================================================
  // Configuration writes; axes 0..3 share each per-axis word, axis chosen by address[1:0]
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      backlash_mode_settings <= `APG_BL_MODE_RST;
      drive_alarm_polarity   <= `APG_ALM_POL_RST;
      drive_alarm_masks      <= `APG_ALM_MASK_RST;
      dir_invert             <= `APG_DIR_INV_RST;
      int_mask               <= 8'h00;
    end else if (i_ce && wr && i_avs_byteenable[0]) begin
      case (i_avs_address)
        {`APG_REG_BL_MODE, 2'h0}:  backlash_mode_settings <= i_avs_writedata[7:0];
        {`APG_REG_ALM_POL, 2'h0}:  drive_alarm_polarity   <= i_avs_writedata[7:0];
        {`APG_REG_ALM_MASK, 2'h0}: drive_alarm_masks      <= i_avs_writedata[7:0];
        {`APG_REG_DIR_INV, 2'h0}:  dir_invert             <= i_avs_writedata[7:0];
        {`APG_REG_INT_MASK, 2'h0}: int_mask               <= i_avs_writedata[7:0];
        default: ;
      endcase
    end
  end

  // Per-axis tables: axes 0..3 by address[1:0], axis 4 in words 0xc..0xf
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_axcfg
      always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          gear_num[g]  <= `APG_GEAR_RST;
          gear_den[g]  <= `APG_GEAR_RST;
          bl_amount[g] <= `APG_BL_AMT_RST;
          bl_cfg[g]    <= `APG_BL_CFG_RST;
        end else if (i_ce && wr && i_avs_byteenable[1:0] == 2'h3 &&
                     axis_sel == 3'(g)) begin
          case (idx)
            `APG_REG_GEAR_NUM: gear_num[g]  <= i_avs_writedata[15:0];
            `APG_REG_GEAR_DEN: gear_den[g]  <= i_avs_writedata[15:0];
            `APG_REG_BL_AMT:   bl_amount[g] <= i_avs_writedata[15:0];
            `APG_REG_BL_CFG:   bl_cfg[g]    <= i_avs_writedata[7:0];
            default: ;
          endcase
        end
      end
      apg_axis u_axis (
        .i_sys_clk    (i_sys_clk),
        .i_nrst       (i_nrst),
        .i_ce         (i_ce),
        .i_cmd        (i_cmd[g]),
        .i_gear_num   (gear_num[g]),
        .i_gear_den   (gear_den[g]),
        .i_bl_amount  (bl_amount[g]),
        .i_bl_cfg     (bl_cfg[g]),
        .i_vel_method (backlash_mode_settings[`APG_BL_VEL_BIT]),
        .i_dir_inv    (dir_invert[g]),
        .o_out        (o_drv[g]),
        .o_bl_busy    (bl_busy[g]),
        .o_bl_done    (bl_done[g])
      );
    end
  endgenerate

  assign o_block_hold = backlash_mode_settings[`APG_BL_WAIT_BIT] && (|bl_busy);

  // ==========================================================
  // Alarm qualification
  always_comb begin
    // polarity: one means high is alarm
    raw_alarm = ~({i_spindle_alarm, i_axis_alarm} ^ drive_alarm_polarity[5:0]);
    if (drive_alarm_masks[`APG_FEED_ALARM_MASK_BIT]) begin
      raw_alarm[4:0] = 5'h00;
    end
    if (drive_alarm_masks[`APG_SPINDLE_ALARM_MASK_BIT]) begin
      raw_alarm[5] = 1'b0;
    end
  end

  // latched per-source alarm, reset op clears
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_drive_alarm <= 6'h00;
    end else if (i_ce) begin
      o_drive_alarm <= (i_alarm_reset ? 6'h00 : o_drive_alarm) | raw_alarm;
    end
  end

  // ==========================================================
  // Interrupt status: bits 0..5 alarm rise, bit 6 backlash done
  assign int_ev = {1'b0, |bl_done, raw_alarm & ~o_drive_alarm};
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      int_status <= 8'h00;
    end else if (i_ce) begin
      // Set wins; a read clears only what it reported, so no late event is lost
      if (rd && idx == `APG_REG_INT_STAT) begin
        int_status <= (int_status & ~o_avs_readdata[7:0]) | int_ev;
      end else begin
        int_status <= int_status | int_ev;
      end
    end
  end
  assign o_irq = |(int_status & int_mask);

  // ==========================================================
  // Read data, registered; global words ignore address[1:0], so every address is mapped
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_ce && i_avs_read && !ack) begin
      case (idx)
        `APG_REG_BL_MODE:  o_avs_readdata <= {24'h0, backlash_mode_settings};
        `APG_REG_ALM_POL:  o_avs_readdata <= {24'h0, drive_alarm_polarity};
        `APG_REG_ALM_MASK: o_avs_readdata <= {24'h0, drive_alarm_masks};
        `APG_REG_DIR_INV:  o_avs_readdata <= {24'h0, dir_invert};
        `APG_REG_INT_STAT: o_avs_readdata <= {24'h0, int_status};
        `APG_REG_INT_MASK: o_avs_readdata <= {24'h0, int_mask};
        `APG_REG_ALM_STAT: o_avs_readdata <= {26'h0, o_drive_alarm};
        `APG_REG_BUSY:     o_avs_readdata <= {27'h0, bl_busy};
        `APG_REG_GEAR_NUM: o_avs_readdata <= {16'h0, gear_num[axis_sel]};
        `APG_REG_GEAR_DEN: o_avs_readdata <= {16'h0, gear_den[axis_sel]};
        `APG_REG_BL_AMT:   o_avs_readdata <= {16'h0, bl_amount[axis_sel]};
        `APG_REG_BL_CFG:   o_avs_readdata <= {24'h0, bl_cfg[axis_sel]};
        default:           o_avs_readdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// [dv/apg_top_props.sv]
/*
  Port checker for the axis pulse block, bound to apg_top below.
  Assumes one clock domain and the asynchronous active-low reset.
*/
`timescale 1ns/10ps
module apg_top_props (
  input wire logic                i_sys_clk,
  input wire logic                i_nrst,
  input wire logic                i_ce,
  input wire logic                i_avs_read,
  input wire logic                i_avs_write,
  input wire logic                i_alarm_reset,
  input wire apg_pkg::apg_pulse_s i_cmd [5],
  input wire apg_pkg::apg_pulse_s o_drv [5],
  input wire logic                o_avs_waitrequest,
  input wire logic [31:0]         o_avs_readdata,
  input wire logic [5:0]          o_drive_alarm
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  // ==========================================================
  // Bus handshake: one wait cycle, then the answer
  a_wait_first: assert property ($rose(i_avs_read || i_avs_write) // bus
    |-> o_avs_waitrequest ##1 !o_avs_waitrequest) else $error("wait cycle wrong");
  a_wait_once: assert property (o_avs_waitrequest |=> !o_avs_waitrequest) // bus
    else $error("waitrequest held too long");
  a_wait_cause: assert property (o_avs_waitrequest |-> i_avs_read || i_avs_write) // bus
    else $error("waitrequest without access");
  a_rdata_hold: assert property (!$past(i_avs_read) |-> $stable(o_avs_readdata)) // bus
    else $error("readdata moved without read");
  // ==========================================================
  // Alarm latch and outputs
  a_alarm_latch: assert property (!$past(i_alarm_reset) && !$past(i_alarm_reset, 2)
    |-> (o_drive_alarm & $past(o_drive_alarm)) == $past(o_drive_alarm))
    else $error("latched alarm dropped without reset");
  a_ce_freeze: assert property (!i_ce |=> $stable(o_drive_alarm))
    else $error("alarm moved while frozen");
  a_step_pulse: assert property (o_drv[0].step |=> !o_drv[0].step)
    else $error("step output longer than a cycle");
  a_dir_cause: assert property ($changed(o_drv[1].dir_neg) |-> $past(i_cmd[1].step)
    || $past(i_cmd[1].step, 2) || $past(i_avs_write) || $past(i_avs_write, 2))
    else $error("direction changed without cause");
endmodule
bind apg_top apg_top_props i_apg_top_props (.i_sys_clk, .i_nrst, .i_ce, .i_avs_read,
  .i_avs_write, .i_alarm_reset, .i_cmd, .o_drv, .o_avs_waitrequest, .o_avs_readdata,
  .o_drive_alarm);

// [dv/apg_drive_model.sv]
/*
  Drive-side model: five step counters and six alarm lines.
  Assumes step pulses one cycle wide on the system clock.
*/
`timescale 1ns/10ps
module apg_drive_model (
  input  wire logic                i_sys_clk,
  input  wire apg_pkg::apg_pulse_s i_drv [5],
  output logic [4:0]               o_axis_alarm,
  output logic                     o_spindle_alarm
);
  logic [5:0] lvl;
  int         pos   [5] = '{default: 0};
  int         gap   [5] = '{default: 0};
  int         since [5] = '{default: 0};
  // alarm lines always driven, set by bench
  assign o_axis_alarm    = lvl[4:0];
  assign o_spindle_alarm = lvl[5];
  always @(posedge i_sys_clk) begin
    for (int k = 0; k < 5; k++) begin
      since[k] <= since[k] + 1;
      if (i_drv[k].step === 1'b1) begin
        pos[k]   <= pos[k] + ((i_drv[k].dir_neg === 1'b1) ? -1 : 1);
        gap[k]   <= since[k] + 1;
        since[k] <= 0;
      end
    end
  end
endmodule

// [dv/apg_top_tb.sv]
/*
  Self-checking bench for apg_top over its Avalon-MM slave.
  Assumes the drive model and the bound checker are compiled first.
*/
`timescale 1ns/10ps
`include "apg_cfg.svh"
module apg_top_tb;
  logic                i_sys_clk   = 1'b0;
  logic                i_nrst      = 1'b0;
  logic                ce          = 1'b1;
  logic                rd          = 1'b0;
  logic                wr          = 1'b0;
  logic                alm_rst     = 1'b0;
  logic [5:0]          ad          = 6'h00;
  logic [31:0]         wd          = 32'h0;
  logic [31:0]         rdata;
  logic                wq;
  apg_pkg::apg_pulse_s cmd [5]     = '{default: '0};
  apg_pkg::apg_pulse_s drv [5];
  logic [4:0]          ax_alm;
  logic                sp_alm;
  logic                hold;
  logic [5:0]          dalm;
  logic                irq;
  int                  n_mismatch  = 0;
  int                  check_count = 0;
  // Free-running system clock
  always #25 i_sys_clk = ~i_sys_clk;
  apg_top i_apg_top (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_ce(ce), .i_avs_address(ad),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wq), .i_cmd(cmd), .o_drv(drv),
    .i_axis_alarm(ax_alm), .i_spindle_alarm(sp_alm), .i_alarm_reset(alm_rst),
    .o_block_hold(hold), .o_drive_alarm(dalm), .o_irq(irq));
  apg_drive_model i_apg_drive_model (.i_sys_clk(i_sys_clk), .i_drv(drv),
    .o_axis_alarm(ax_alm), .o_spindle_alarm(sp_alm));
  // ==========================================================
  // Helpers
  function automatic logic [5:0] ba(input logic [3:0] idx, input logic [1:0] ax);
    return {idx, ax};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Request held until the edge where waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    rd <= ~w;
    wr <= w;
    ad <= a;
    wd <= d;
    // Waitrequest and read data are both taken at the rising edge
    @(posedge i_sys_clk);
    while (wq !== 1'b0 && n < 64) begin
      @(posedge i_sys_clk);
      n++;
    end
    if (n == 64) n_mismatch++;
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wreg(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask
  task automatic step(input int k, input logic neg);
    @(posedge i_sys_clk);
    cmd[k] <= '{step: 1'b1, dir_neg: neg};
    @(posedge i_sys_clk);
    cmd[k].step <= 1'b0;
    repeat (8) @(posedge i_sys_clk);
  endtask
  task automatic settle();
    repeat (6) @(posedge i_sys_clk);
  endtask
  // Poll the busy word; bounded so a stuck engine cannot hang
  task automatic drain();
    logic [31:0] r;
    int          n;
    n = 0;
    r = 32'h1;
    while (r !== 32'h0 && n < 2000) begin
      bus(1'b0, ba(`APG_REG_BUSY, 2'h0), 32'h0, r);
      n++;
    end
    chk(r, 32'h0);
    settle();
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Watchdog sized well past the longest ramp
  initial begin
    #3000000;
    n_mismatch++;
    tally_and_finish();
  end
  // ==========================================================
  // Main sequence
  initial begin
    i_apg_drive_model.lvl = 6'h00;
    repeat (16) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    rchk(ba(`APG_REG_BL_MODE, 2'h0), 32'h0);
    rchk(ba(`APG_REG_DIR_INV, 2'h0), 32'h0);
    rchk(ba(`APG_REG_GEAR_NUM, 2'h0), 32'h1);
    rchk(ba(`APG_REG_BL_CFG, 2'h1), 32'h10);
    rchk(6'h30, 32'h1);
    chk(dalm, 6'h3f);
    rchk(ba(`APG_REG_ALM_STAT, 2'h0), 32'h3f);
    i_apg_drive_model.lvl <= 6'h3f;
    settle();
    chk(dalm, 6'h3f);
    alm_rst <= 1'b1;
    settle();
    alm_rst <= 1'b0;
    settle();
    chk(dalm, 6'h00);
    // Gear 5/4 on axis one: eight commands give ten pulses
    wreg(ba(`APG_REG_GEAR_NUM, 2'h0), 32'h5);
    wreg(ba(`APG_REG_GEAR_DEN, 2'h0), 32'h4);
    for (int i = 0; i < 8; i++) step(0, 1'b0);
    chk(i_apg_drive_model.pos[0], 32'ha);
    // Axis three left at unity gear: one command, one pulse
    step(2, 1'b0);
    chk(i_apg_drive_model.pos[2], 32'h1);
    wreg(ba(`APG_REG_DIR_INV, 2'h0), 32'h1);
    step(0, 1'b0);
    chk(i_apg_drive_model.pos[0], 32'h9);
    chk(drv[0].dir_neg, 1'b1);
    // Backlash on axis two, fixed rate with block wait
    rchk(ba(`APG_REG_INT_STAT, 2'h0), 32'h3f);
    wreg(ba(`APG_REG_BL_AMT, 2'h1), 32'h3);
    wreg(ba(`APG_REG_BL_CFG, 2'h1), 32'h1);
    wreg(ba(`APG_REG_BL_MODE, 2'h0), 32'h1);
    step(1, 1'b0);
    step(1, 1'b0);
    chk(i_apg_drive_model.pos[1], 32'h2);
    step(1, 1'b1);
    chk(hold, 1'b1);
    // Between the second and third compensation pulse
    repeat (40) @(posedge i_sys_clk);
    chk(i_apg_drive_model.gap[1], 32'h11);
    drain();
    chk(hold, 1'b0);
    chk(i_apg_drive_model.pos[1], 32'hffff_fffe);
    rchk(ba(`APG_REG_INT_STAT, 2'h0), 32'h40);
    // Ramped method, no block wait
    wreg(ba(`APG_REG_BL_MODE, 2'h0), 32'h80);
    step(1, 1'b0);
    chk(hold, 1'b0);
    // Three pulses close to the stop: the ramp stays at its start period
    repeat (2100) @(posedge i_sys_clk);
    chk(i_apg_drive_model.gap[1], 32'h400);
    drain();
    chk(i_apg_drive_model.pos[1], 32'h2);
    // Polarity, masks and interrupt
    wreg(ba(`APG_REG_ALM_MASK, 2'h0), 32'h24);
    wreg(ba(`APG_REG_ALM_POL, 2'h0), 32'h3f);
    settle();
    chk(dalm, 6'h00);
    rchk(ba(`APG_REG_INT_STAT, 2'h0), 32'h40);
    wreg(ba(`APG_REG_INT_MASK, 2'h0), 32'h7f);
    wreg(ba(`APG_REG_ALM_MASK, 2'h0), 32'h20);
    settle();
    chk(dalm, 6'h20);
    chk(irq, 1'b1);
    wreg(ba(`APG_REG_ALM_MASK, 2'h0), 32'h0);
    settle();
    chk(dalm, 6'h3f);
    rchk(ba(`APG_REG_INT_STAT, 2'h0), 32'h3f);
    // The clear lands at the completion edge; look one cycle later
    @(posedge i_sys_clk);
    chk(irq, 1'b0);
    i_apg_drive_model.lvl <= 6'h00;
    alm_rst <= 1'b1;
    settle();
    alm_rst <= 1'b0;
    wreg(ba(`APG_REG_INT_MASK, 2'h0), 32'h0);
    i_apg_drive_model.lvl <= 6'h04;
    settle();
    chk(dalm, 6'h04);
    chk(irq, 1'b0);
    // Clock enable low for one cycle freezes state
    ce <= 1'b0;
    @(posedge i_sys_clk);
    ce <= 1'b1;
    settle();
    chk(dalm, 6'h04);
    tally_and_finish();
  end
endmodule
